// ==== common/two_wire_pkg.sv ====
// Shared types and constants for the two-wire register slave.
// Assumes a single 125 MHz system clock; the serial clock is sampled as data.
package two_wire_pkg;

    // ------------------------------------------------------------
    // Slave addresses (seven-bit form)
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_PRIMARY   = 7'h48;   // 0x90 / 0x91 on the wire
    localparam logic [6:0] ADDR_ALTERNATE = 7'h5D;   // 0xBA / 0xBB on the wire

    // ------------------------------------------------------------
    // Field positions, last bit index, register-address reset value and step
    // ------------------------------------------------------------
    localparam int          DIR_BIT      = 0;
    localparam int          ADDR_MSB     = 7;
    localparam int          ADDR_LSB     = 1;
    localparam logic [2:0]  LAST_BIT_IDX = 3'h7;
    localparam logic [15:0] REG_ADDR_RST = 16'h0000;
    localparam logic [15:0] REG_ADDR_INC = 16'h0001;

    // ------------------------------------------------------------
    // Line events seen after synchronising
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } line_event_type;

    // ------------------------------------------------------------
    // Register-file access from the slave
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_type;

endpackage

// ==== hw/line_sampler.sv ====
// Two-flop synchroniser and edge finder for the serial clock and data pins.
// Assumes both pins come from outside the system clock domain.
`timescale 1ns/1ns
module line_sampler
    import two_wire_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           rst,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output line_event_type      events
);

    typedef struct packed {
        logic [1:0] scl_meta;
        logic [1:0] sda_meta;
        logic       scl_prev;
        logic       sda_prev;
    } sampler_state_type;

    sampler_state_type st_q;
    sampler_state_type st_d;

    always_comb begin
        st_d          = st_q;
        st_d.scl_meta = {st_q.scl_meta[0], scl_in};
        st_d.sda_meta = {st_q.sda_meta[0], sda_in};
        st_d.scl_prev = st_q.scl_meta[1];
        st_d.sda_prev = st_q.sda_meta[1];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Edge and condition detection on the second-stage flops and their one-cycle delayed copies
    // ------------------------------------------------------------
    always_comb begin
        events.scl_rise = st_q.scl_meta[1] & ~st_q.scl_prev;
        events.scl_fall = ~st_q.scl_meta[1] & st_q.scl_prev;
        events.start    = st_q.scl_meta[1] & st_q.scl_prev
                          & st_q.sda_prev & ~st_q.sda_meta[1];
        events.stop     = st_q.scl_meta[1] & st_q.scl_prev
                          & ~st_q.sda_prev & st_q.sda_meta[1];
        events.sda      = st_q.sda_meta[1];
    end

endmodule

// ==== hw/two_wire_register_slave.sv ====
// Slave end of the two-wire register port: 16-bit addresses, 16-bit data.
// Assumes an external register file answering reads combinationally on rd_data.
`timescale 1ns/1ns

// What this block does
// - Address byte: bits 7..1 slave address, bit 0 direction, one means read.
// - Select pin low: answer 0x90 for writes, 0x91 for reads.
// - Select pin high: answer 0xBA for writes, 0xBB for reads.
// - Ninth clock after each byte is acknowledge; receiver pulls data low.
// - Transmitter releases the data line during the acknowledge clock.
// - Data changes only while clock low; stable while clock high.
// - Data left high in acknowledge means no-acknowledge; ends a read.
// - Stop is data rising while clock high; only master makes it.
// - Acknowledge address byte only when seven-bit address matches selection.
// - Write sends 16-bit register address, high byte first, each acknowledged.
// - Then 16-bit data as two bytes, each acknowledged.
// - Random read: write address, register address, restart, read address.
// - Read without register address uses the address left before.
// - A single register read gives two bytes, high byte first.
// - Sequential read continues while the master acknowledges.
// - Sequential write continues with more data bytes until stop.
// - Start is data falling while clock high; restart needs no stop.
// - Bytes shift most significant bit first, one bit per clock.
// - Bus idle when both lines high; only master starts.
module two_wire_register_slave
    import two_wire_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          address_select_pin,
    input  wire logic          scl_in,
    input  wire logic          serial_data_line_in,
    output logic               serial_data_line_out,
    output logic               serial_data_line_oe,
    output reg_req_type        reg_req,
    input  wire logic [15:0]   rd_data,
    output logic               busy
);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK
    } phase_type;

    typedef enum logic [2:0] {
        B_DEV,
        B_AHI,
        B_ALO,
        B_DHI,
        B_DLO
    } byte_role_type;

    typedef struct packed {
        phase_type     phase;
        byte_role_type role;
        logic          reading;
        logic          ack_drive;
        logic [2:0]    bit_idx;
        logic          byte_full;
        logic [7:0]    shift;
        logic [15:0]   reg_addr;
        logic [7:0]    data_hi;
        logic          read_lo;
        logic          sda_out;
        logic          sda_oe;
        reg_req_type   req;
    } slave_state_type;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] next_addr(input logic [15:0] a);
        next_addr = a + REG_ADDR_INC;
    endfunction

    function automatic logic [6:0] own_address(input logic sel);
        own_address = sel ? ADDR_ALTERNATE : ADDR_PRIMARY;
    endfunction

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    line_event_type ev;

    line_sampler u_sampler (
        .clock  (clock),
        .rst    (rst),
        .scl_in (scl_in),
        .sda_in (serial_data_line_in),
        .events (ev)
    );

    logic [1:0] sel_sync_q;
    logic [1:0] sel_sync_d;

    assign sel_sync_d = {sel_sync_q[0], address_select_pin};

    always_ff @(posedge clock) begin
        if (rst) begin
            sel_sync_q <= 2'h0;
        end else begin
            sel_sync_q <= sel_sync_d;
        end
    end

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    slave_state_type st_q;
    slave_state_type st_d;

    logic [7:0] next_shift;
    logic [7:0] tx_byte;

    always_comb begin
        st_d       = st_q;
        st_d.req   = '0;
        st_d.req.addr  = st_q.reg_addr;
        next_shift = {st_q.shift[6:0], ev.sda};
        tx_byte    = st_q.read_lo ? rd_data[7:0] : rd_data[15:8];

        if (ev.stop) begin
            st_d.phase  = ST_IDLE;
            st_d.sda_oe = 1'b0;
        end else if (ev.start) begin
            st_d.phase   = ST_RECV;
            st_d.role    = B_DEV;
            st_d.bit_idx = 3'h0;
            st_d.byte_full = 1'b0;
            st_d.sda_oe  = 1'b0;
        end else begin
            unique case (st_q.phase)
                ST_IDLE: begin
                    st_d.sda_oe = 1'b0;
                end
                ST_RECV: begin
                    if (ev.scl_rise) begin
                        st_d.shift   = next_shift;
                        st_d.bit_idx = st_q.bit_idx + 3'h1;
                        st_d.byte_full = (st_q.bit_idx == LAST_BIT_IDX);
                    end else if (ev.scl_fall && st_q.byte_full) begin
                        // Eight bits taken: the clock fall after a start is not a byte
                        st_d.byte_full = 1'b0;
                        st_d.phase     = ST_ACK;
                        st_d.ack_drive = 1'b1;
                        unique case (st_q.role)
                            B_DEV: begin
                                if (st_q.shift[ADDR_MSB:ADDR_LSB] ==
                                    own_address(sel_sync_q[1])) begin
                                    st_d.reading = st_q.shift[DIR_BIT];
                                    st_d.read_lo = 1'b0;
                                end else begin
                                    st_d.phase     = ST_IDLE;
                                    st_d.ack_drive = 1'b0;
                                end
                            end
                            B_AHI: st_d.reg_addr[15:8] = st_q.shift;
                            B_ALO: st_d.reg_addr[7:0]  = st_q.shift;
                            B_DHI: st_d.data_hi        = st_q.shift;
                            B_DLO: begin
                                st_d.req.wr_en = 1'b1;
                                st_d.req.wdata = {st_q.data_hi, st_q.shift};
                            end
                            default: st_d.phase = ST_IDLE;
                        endcase
                        if (st_d.phase == ST_ACK) begin
                            st_d.sda_out = 1'b0;
                            st_d.sda_oe  = 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (ev.scl_fall) begin
                        st_d.bit_idx = 3'h0;
                        if (st_q.reading) begin
                            st_d.phase   = ST_SEND;
                            st_d.sda_out = tx_byte[LAST_BIT_IDX];
                            st_d.sda_oe  = ~tx_byte[LAST_BIT_IDX];
                            st_d.req.rd_en = 1'b1;
                            st_d.shift   = {tx_byte[6:0], 1'b1};
                        end else begin
                            st_d.phase  = ST_RECV;
                            st_d.sda_oe = 1'b0;
                            unique case (st_q.role)
                                B_DEV:   st_d.role = B_AHI;
                                B_AHI:   st_d.role = B_ALO;
                                B_ALO:   st_d.role = B_DHI;
                                B_DHI:   st_d.role = B_DLO;
                                B_DLO: begin
                                    st_d.role     = B_DHI;
                                    st_d.reg_addr = next_addr(st_q.reg_addr);
                                end
                                default: st_d.role = B_DEV;
                            endcase
                        end
                    end
                end
                ST_SEND: begin
                    if (ev.scl_fall) begin
                        st_d.bit_idx = st_q.bit_idx + 3'h1;
                        if (st_q.bit_idx == LAST_BIT_IDX) begin
                            st_d.phase  = ST_MACK;
                            st_d.sda_oe = 1'b0;
                        end else begin
                            st_d.sda_oe = ~st_q.shift[LAST_BIT_IDX];
                            st_d.shift  = {st_q.shift[6:0], 1'b1};
                        end
                    end
                end
                ST_MACK: begin
                    if (ev.scl_rise) begin
                        if (st_q.read_lo) begin
                            st_d.reg_addr = next_addr(st_q.reg_addr);
                        end
                        if (ev.sda) begin
                            st_d.phase = ST_IDLE;
                        end else begin
                            st_d.phase = ST_ACK;
                            st_d.read_lo = ~st_q.read_lo;
                        end
                    end
                end
                default: st_d.phase = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q          <= '0;
            st_q.phase    <= ST_IDLE;
            st_q.role     <= B_DEV;
            st_q.reg_addr <= REG_ADDR_RST;
            st_q.sda_out  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign serial_data_line_out = 1'b0;
    assign serial_data_line_oe  = st_q.sda_oe;
    assign reg_req              = st_q.req;
    assign busy                 = (st_q.phase != ST_IDLE);

endmodule

// ==== test/host_master_model.sv ====
// Host master model: makes the serial clock and pulls the data wire low.
// Assumes an open-drain data wire with a pull-up resolved by the bench.
`timescale 1ns/1ns
module host_master_model (
    input  wire logic clock,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Also a restart: waits out the slave's late acknowledge release
    task automatic bus_start();
        sda_pull = 1'b0;
        w(5);
        scl = 1'b1;
        w(2);
        sda_pull = 1'b1;
        w(2);
        scl = 1'b0;
    endtask
    task automatic bus_stop();
        sda_pull = 1'b1;
        w(5);
        scl = 1'b1;
        w(2);
        sda_pull = 1'b0;
        w(4);
    endtask
    task automatic bit_io(input logic b, output logic r);
        w(2);
        sda_pull = !b;
        w(2);
        scl = 1'b1;
        w(2);
        r = sda_in;
        w(2);
        scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule

// ==== test/two_wire_slave_monitor.sv ====
// Port checker for the two-wire register slave.
// Assumes it is bound to every instance of the slave.
`timescale 1ns/1ns
module two_wire_slave_monitor
    import two_wire_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        scl_in,
    input wire logic        serial_data_line_in,
    input wire logic        serial_data_line_out,
    input wire logic        serial_data_line_oe,
    input wire reg_req_type reg_req,
    input wire logic        busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [3:0]  hi_cnt_q;
    logic [15:0] wr_addr_q;
    always_ff @(posedge clock) begin
        hi_cnt_q  <= (rst || !scl_in) ? 4'h0 : hi_cnt_q + {3'h0, hi_cnt_q != 4'hF};
        wr_addr_q <= reg_req.wr_en ? reg_req.addr : wr_addr_q;
    end
    sequence start_s;
        scl_in && $past(scl_in) && $fell(serial_data_line_in);
    endsequence
    sequence stop_s;
        scl_in && $past(scl_in) && $rose(serial_data_line_in);
    endsequence
    AST_DRIVE_LOW_ONLY: assert property (!serial_data_line_out)
        else $error("data line driven high");
    AST_OE_CLOCK_LOW: assert property ($changed(serial_data_line_oe) |-> hi_cnt_q < 4'h3)
        else $error("data drive changed deep in clock high");
    AST_IDLE_RELEASED: assert property (!busy |-> !serial_data_line_oe)
        else $error("data line driven while idle");
    AST_START_BUSY: assert property (start_s |-> ##[1:6] busy)
        else $error("start not taken");
    AST_STOP_IDLE: assert property (stop_s |-> ##[1:8] !busy)
        else $error("stop not taken");
    AST_WR_PULSE: assert property (reg_req.wr_en |-> busy ##1 !reg_req.wr_en)
        else $error("write pulse too long");
    AST_RD_PULSE: assert property (reg_req.rd_en |-> busy ##1 !reg_req.rd_en)
        else $error("read pulse too long");
    AST_WORD_ADVANCE: assert property (reg_req.wr_en |-> ##[1:16] reg_req.addr == wr_addr_q + 16'h1)
        else $error("address did not advance after word");
    AST_IDLE_ADDR: assert property (!busy && !$past(busy) && !$past(busy, 2) |-> $stable(reg_req.addr))
        else $error("address moved while idle");
endmodule
bind two_wire_register_slave two_wire_slave_monitor mon (.clock(clock), .rst(rst),
    .scl_in(scl_in), .serial_data_line_in(serial_data_line_in),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
    .reg_req(reg_req), .busy(busy));

// ==== test/tb_top.sv ====
// Self-checking bench: host master model drives the slave, a word model checks it.
// Assumes the master model and the port checker are compiled with it.
`timescale 1ns/1ns
module tb_top
    import two_wire_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        sel = 1'b0;
    logic        scl, pull, sda_out, sda_oe, busy;
    wire logic   sda = !(pull || sda_oe);
    reg_req_type req;
    logic [15:0] rd_data;
    logic [15:0] mem [256];
    int          em [256];
    logic [31:0] wq [$];
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [31:0] seed = 32'h18;
    logic [15:0] ptr = 16'h0000;
    logic [15:0] ra;
    always #4 clock = !clock;
    assign rd_data = mem[req.addr[7:0]];
    two_wire_register_slave dut (.clock(clock), .rst(rst), .address_select_pin(sel),
        .scl_in(scl), .serial_data_line_in(sda), .serial_data_line_out(sda_out),
        .serial_data_line_oe(sda_oe), .reg_req(req), .rd_data(rd_data), .busy(busy));
    host_master_model m (.clock(clock), .sda_in(sda), .scl(scl), .sda_pull(pull));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        if (req.wr_en === 1'b1) begin
            mem[req.addr[7:0]] <= req.wdata;
            chk({req.addr, req.wdata}, (wq.size() > 0) ? wq.pop_front() : 32'hX);
        end
    end
    task automatic stop_idle();
        m.bus_stop();
        repeat (6) @(negedge clock);
        chk(32'(busy), 32'h0);
    endtask
    task automatic put_addr(input logic [7:0] a, input logic [15:0] r, input logic ok);
        logic ack;
        m.bus_start();
        m.send(a, ack);
        chk(32'(ack), 32'(ok));
        for (int i = 1; ok && i >= 0; i--) begin
            m.send(r[8*i+:8], ack);
            chk(32'(ack), 32'h1);
        end
        if (ok) ptr = r;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] r, input int nb, input logic ok);
        logic ack;
        logic [15:0] v;
        put_addr(a, r, ok);
        for (int i = 0; ok && i < nb; i++) begin
            if (i % 2 == 0) v = 16'(rnd());
            if (i % 2 == 1) begin
                wq.push_back({ptr, v});
                em[ptr[7:0]] = 32'(v);
                ptr++;
            end
            m.send((i % 2 == 0) ? v[15:8] : v[7:0], ack);
            chk(32'(ack), 32'h1);
        end
        stop_idle();
    endtask
    task automatic rd(input logic [7:0] a, input int nb);
        logic ack;
        logic [7:0] d;
        logic [15:0] e;
        m.bus_start();
        m.send(a | 8'h01, ack);
        chk(32'(ack), 32'h1);
        for (int i = 0; i < nb; i++) begin
            e = 16'(em[ptr[7:0]]);
            m.recv(i < nb - 1, d);
            chk(32'(d), 32'((i % 2 == 0) ? e[15:8] : e[7:0]));
            if (i % 2 == 1) ptr++;
        end
        stop_idle();
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'(i * 257) ^ 16'h5A3C;
            em[i] = 32'(mem[i]);
        end
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        for (int s = 0; s < 2; s++) begin
            sel = s[0];
            repeat (8) @(negedge clock);
            ra = 16'(rnd());
            wr(s ? 8'hBA : 8'h90, ra, 6, 1'b1);
            wr(s ? 8'h90 : 8'hBA, ra, 2, 1'b0);
            put_addr(s ? 8'hBA : 8'h90, ra, 1'b1);
            rd(s ? 8'hBA : 8'h90, 4);
            rd(s ? 8'hBA : 8'h90, 2);
            wr(s ? 8'hBA : 8'h90, ra + 16'h7, 1, 1'b1);
            rd(s ? 8'hBA : 8'h90, 2);
            $display("address select %0d test done", s);
        end
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        $display("MISMATCH %0t run did not finish", $time);
        finish_test();
    end
endmodule
